//--- rtl/gpmc_defs.svh
// Offsets, field positions, reset values and timing counts of the mode control.
`ifndef GPMC_DEFS_SVH
`define GPMC_DEFS_SVH
`define GPMC_ADR_CFG 8'h00
`define GPMC_ADR_CMD 8'h04
`define GPMC_ADR_SLEEP_CUR 8'h08
`define GPMC_ADR_HIB_CUR 8'h0C
`define GPMC_ADR_HIB_VOLT 8'h10
`define GPMC_ADR_FLASH_VOLT 8'h14
`define GPMC_ADR_WAIT 8'h18
`define GPMC_ADR_STATUS 8'h1C
`define GPMC_ADR_RST_CNT 8'h20
`define GPMC_ADR_OFFSET 8'h24
`define GPMC_CFG_SLEEP_EN 0
`define GPMC_CFG_DOZE_EN 1
`define GPMC_CFG_HIB_REQ 2
`define GPMC_CFG_HDQ_SEL 3
`define GPMC_CFG_WAKE_RANGE 4
`define GPMC_CFG_RS_LO 5
`define GPMC_CFG_RS_HI 6
`define GPMC_CFG_RESET 7'h00
`define GPMC_CMD_DOZE_ARM 8'h01
`define GPMC_CMD_RESET_FULL 8'h02
`define GPMC_CMD_RESET_PART 8'h03
`define GPMC_THR_1P0 16'h000A
`define GPMC_THR_2P2 16'h0016
`define GPMC_THR_4P6 16'h002E
`define GPMC_THR_9P8 16'h0062
`define GPMC_TEMP_LO_C 8'h05
`define GPMC_TEMP_HI_C 8'h2D
`define GPMC_CAL_CUR_MA 16'h0064
`define GPMC_CAL_DV_MV 16'h0100
`define GPMC_CAL_DT_C 8'h08
`define GPMC_ABORT_MV 16'h0020
`define GPMC_CLK_HZ 32'h00989680
`define GPMC_STRETCH_US 32'h00000FA0
`define GPMC_FREEZE_S 32'h00000003
`define GPMC_TEMP_HOLD_S 32'h0000003C
`define GPMC_STRETCH_CYC (`GPMC_STRETCH_US * (`GPMC_CLK_HZ / 32'h000F4240))
`define GPMC_FREEZE_CYC (`GPMC_FREEZE_S * `GPMC_CLK_HZ)
`define GPMC_TEMP_HOLD_CYC (`GPMC_TEMP_HOLD_S * `GPMC_CLK_HZ)
`endif

//--- rtl/gpmc_pkg.sv
// Types shared by the power mode control.
package gpmc_pkg;
	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_CAL_PRE,
		ST_SLEEP,
		ST_DOZE,
		ST_HIBER
	} gpmc_state_type;
	typedef struct packed {
		logic [15:0] avg_current;
		logic [15:0] voltage;
		logic [7:0] temperature;
		logic [15:0] sense_raw;
	} gpmc_meas_type;
endpackage : gpmc_pkg

//--- rtl/gpmc_top.sv
// Power mode sequencer of the fuel gauge with its Wishbone register file.
// How it works
// - Stay in normal mode, measure and refresh data unless another mode applies.
// - Enter sleep only with sleep enabled and average current below sleep level.
// - Run an offset calibration after sleep entry qualifies, before sleeping.
// - In sleep or doze, hold comm lines low up to 4 ms on traffic.
// - Leave sleep when current exceeds sleep level or wake comparator fires.
// - From sleep with doze enabled, doze when wait timer reaches zero.
// - Traffic ends doze; doze enable clears when wait time is zero.
// - In doze, stop the fast oscillator yet keep measuring.
// - Hibernate needs valid OCV, small current, and low voltage or request.
// - Stay in hibernate until traffic addressed to this device arrives.
// - Waking from hibernate clears the hibernate request bit.
// - After hibernate, keep reporting old values for about 3 seconds.
// - Shutdown pin function only when hibernate came from low voltage.
// - Hibernate is never entered while the single-wire link is selected.
// - Reset subcommands are classified and counted; counts are readable.
// - Wake threshold follows range and select bits; zero selects disable.
// - Wake comparator flags crossings in charge and discharge directions.
// - Refuse flash updates below the flash voltage limit.
// - Subtract measured offset from raw sense voltage.
// - Skip sleep-entry calibration at or below 5 C, at or above 45 C.
// - Calibrate on small current with large voltage or lasting temperature change.
// - Hold accounting during calibration; abort on voltage drop above 32 mV.
//
// Implementation choices: the Wishbone register port and the register addresses.
`include "gpmc_defs.svh"
module gpmc_top #(
	parameter logic [31:0] STRETCH_CYCLES = `GPMC_STRETCH_CYC,
	parameter logic [31:0] FREEZE_CYCLES = `GPMC_FREEZE_CYC,
	parameter logic [31:0] TEMP_HOLD_CYCLES = `GPMC_TEMP_HOLD_CYC
)(
	input wire logic clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire gpmc_pkg::gpmc_meas_type meas,
	input wire logic meas_tick,
	input wire logic ocv_valid,
	input wire logic cal_done,
	input wire logic [15:0] offset_meas,
	input wire logic addressed_self,
	input wire logic flash_req,
	input wire logic comm_line_pin,
	output gpmc_pkg::gpmc_state_type power_state,
	output logic hf_osc_enable,
	output logic line_hold_low,
	output logic cal_run,
	output logic flash_grant,
	output logic flash_refused,
	output logic shutdown_enable_pin,
	output logic report_frozen,
	output logic data_refresh,
	output logic [15:0] current_corrected,
	output logic wake_irq
);
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] din, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				r[i*8 +: 8] = din[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [15:0] mag(input logic [15:0] v);
		return v[15] ? 16'(-v) : v;
	endfunction : mag

	logic [6:0] cfg;
	logic [15:0] sleep_cur;
	logic [15:0] hib_cur;
	logic [15:0] hib_volt;
	logic [15:0] flash_volt;
	logic [15:0] wait_time;
	logic [7:0] cnt_full;
	logic [7:0] cnt_part;
	logic [15:0] offset;
	logic [15:0] wait_cnt;
	logic [31:0] hold_cnt;
	logic [31:0] freeze_cnt;
	logic [31:0] temp_cnt;
	logic [15:0] cal_v_start;
	logic [15:0] v_ref;
	logic [7:0] t_ref;
	logic sync1;
	logic sync2;
	logic sync3;
	logic wake_prev;
	gpmc_pkg::gpmc_state_type next_state;

	// Register bus decode.
	wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire bus_wr = bus_req && wb_we_i;
	wire wr_cfg = bus_wr && wb_adr_i == `GPMC_ADR_CFG;
	wire wr_cmd = bus_wr && wb_adr_i == `GPMC_ADR_CMD && wb_sel_i[0];
	wire [7:0] cmd = wb_dat_i[7:0];
	wire [31:0] cfg_new = merge({25'h0000000, cfg}, wb_dat_i, wb_sel_i);
	wire arm_doze = wr_cmd && cmd == `GPMC_CMD_DOZE_ARM;
	wire [31:0] status_word = {25'h0000000, line_hold_low, report_frozen,
		shutdown_enable_pin, cal_run, power_state};
	logic [31:0] rd_word;
	always_comb
	begin
		case (wb_adr_i)
			`GPMC_ADR_CFG: rd_word = {25'h0000000, cfg};
			`GPMC_ADR_SLEEP_CUR: rd_word = {16'h0000, sleep_cur};
			`GPMC_ADR_HIB_CUR: rd_word = {16'h0000, hib_cur};
			`GPMC_ADR_HIB_VOLT: rd_word = {16'h0000, hib_volt};
			`GPMC_ADR_FLASH_VOLT: rd_word = {16'h0000, flash_volt};
			`GPMC_ADR_WAIT: rd_word = {16'h0000, wait_time};
			`GPMC_ADR_STATUS: rd_word = status_word;
			`GPMC_ADR_RST_CNT: rd_word = {16'h0000, cnt_part, cnt_full};
			`GPMC_ADR_OFFSET: rd_word = {16'h0000, offset};
			default: rd_word = 32'h00000000;
		endcase
	end

	// Measurement decode.
	wire [15:0] avg = meas.avg_current;
	wire [15:0] volt = meas.voltage;
	wire [7:0] temp = meas.temperature;
	wire sleep_ok = cfg[`GPMC_CFG_SLEEP_EN]
		&& $signed(avg) < $signed(sleep_cur);
	wire temp_ok = $signed(temp) > $signed(`GPMC_TEMP_LO_C)
		&& $signed(temp) < $signed(`GPMC_TEMP_HI_C);
	wire hib_ok = !cfg[`GPMC_CFG_HDQ_SEL] && ocv_valid
		&& mag(avg) < hib_cur;
	wire low_cell = volt < hib_volt;
	wire hib_go = hib_ok && (low_cell || cfg[`GPMC_CFG_HIB_REQ]);

	// Wake comparator threshold in units of 0.1 mV.
	logic [15:0] wake_thr;
	wire [2:0] thr_code = {cfg[`GPMC_CFG_WAKE_RANGE], cfg[`GPMC_CFG_RS_HI],
		cfg[`GPMC_CFG_RS_LO]};
	always_comb
	begin
		case (thr_code)
			3'h1: wake_thr = `GPMC_THR_1P0;
			3'h5: wake_thr = `GPMC_THR_2P2;
			3'h2: wake_thr = `GPMC_THR_2P2;
			3'h6: wake_thr = `GPMC_THR_4P6;
			3'h3: wake_thr = `GPMC_THR_4P6;
			3'h7: wake_thr = `GPMC_THR_9P8;
			default: wake_thr = 16'h0000;
		endcase
	end
	wire wake_en = cfg[`GPMC_CFG_RS_HI] || cfg[`GPMC_CFG_RS_LO];
	wire wake_beyond = wake_en
		&& mag(current_corrected) > wake_thr;
	wire wake_hit = wake_beyond && !wake_prev;
	wire sleep_exit = !sleep_ok || wake_hit;

	// Bus activity seen on the line, idle high; a falling edge is traffic.
	wire comm_edge = sync3 && !sync2;
	wire low_power = power_state == gpmc_pkg::ST_SLEEP
		|| power_state == gpmc_pkg::ST_DOZE;

	// Calibration triggers and abort.
	wire [15:0] dv = volt > v_ref ? 16'(volt - v_ref) : 16'(v_ref - volt);
	wire [7:0] dt = $signed(temp) > $signed(t_ref) ? 8'(temp - t_ref)
		: 8'(t_ref - temp);
	wire temp_moved = dt > `GPMC_CAL_DT_C;
	wire periodic_cal = $signed(avg) <= $signed(`GPMC_CAL_CUR_MA)
		&& (dv >= `GPMC_CAL_DV_MV
		|| temp_cnt >= TEMP_HOLD_CYCLES);
	wire cal_abort = cal_run
		&& volt + `GPMC_ABORT_MV < cal_v_start;
	wire cal_finish = cal_run && cal_done && !cal_abort;
	wire entry_cal = power_state == gpmc_pkg::ST_NORMAL && !hib_go
		&& sleep_ok && temp_ok;
	wire cal_start = !cal_run && (entry_cal
		|| (power_state == gpmc_pkg::ST_NORMAL && periodic_cal));
	wire doze_go = cfg[`GPMC_CFG_DOZE_EN]
		&& (wait_time == 16'h0000 || wait_cnt == 16'h0000);

	always_comb
	begin
		next_state = power_state;
		case (power_state)
			gpmc_pkg::ST_NORMAL:
			begin
				if (hib_go)
					next_state = gpmc_pkg::ST_HIBER;
				else if (sleep_ok && temp_ok)
					next_state = gpmc_pkg::ST_CAL_PRE;
				else if (sleep_ok)
					next_state = gpmc_pkg::ST_SLEEP;
				else
					next_state = gpmc_pkg::ST_NORMAL;
			end
			gpmc_pkg::ST_CAL_PRE:
			begin
				if (!sleep_ok)
					next_state = gpmc_pkg::ST_NORMAL;
				else if (cal_finish || cal_abort || !cal_run)
					next_state = gpmc_pkg::ST_SLEEP;
			end
			gpmc_pkg::ST_SLEEP:
			begin
				if (sleep_exit)
					next_state = gpmc_pkg::ST_NORMAL;
				else if (doze_go && !comm_edge)
					next_state = gpmc_pkg::ST_DOZE;
			end
			gpmc_pkg::ST_DOZE:
			begin
				if (sleep_exit)
					next_state = gpmc_pkg::ST_NORMAL;
				else if (comm_edge)
					next_state = gpmc_pkg::ST_SLEEP;
			end
			gpmc_pkg::ST_HIBER:
			begin
				if (addressed_self)
					next_state = gpmc_pkg::ST_NORMAL;
			end
			default: next_state = gpmc_pkg::ST_NORMAL;
		endcase
	end

	wire hib_wake = power_state == gpmc_pkg::ST_HIBER && addressed_self;
	wire doze_leave = power_state == gpmc_pkg::ST_DOZE && comm_edge;
	wire enter_sleep = next_state == gpmc_pkg::ST_SLEEP
		&& power_state != gpmc_pkg::ST_SLEEP;

	// Bus slave: one wait state, unmapped reads give zero.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_word : 32'h00000000;
		end
	end

	// Software writes win over the hardware clears of the same cycle.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			cfg <= `GPMC_CFG_RESET;
		else if (wr_cfg)
			cfg <= cfg_new[6:0];
		else if (arm_doze)
			cfg[`GPMC_CFG_DOZE_EN] <= 1'b1;
		else
		begin
			if (doze_leave && wait_time == 16'h0000)
				cfg[`GPMC_CFG_DOZE_EN] <= 1'b0;
			if (hib_wake)
				cfg[`GPMC_CFG_HIB_REQ] <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			sleep_cur <= 16'h0000;
			hib_cur <= 16'h0000;
			hib_volt <= 16'h0000;
			flash_volt <= 16'h0000;
			wait_time <= 16'h0000;
		end
		else if (bus_wr)
		begin
			case (wb_adr_i)
				`GPMC_ADR_SLEEP_CUR: sleep_cur <= 16'(merge({16'h0000,
					sleep_cur}, wb_dat_i, wb_sel_i));
				`GPMC_ADR_HIB_CUR: hib_cur <= 16'(merge({16'h0000, hib_cur},
					wb_dat_i, wb_sel_i));
				`GPMC_ADR_HIB_VOLT: hib_volt <= 16'(merge({16'h0000,
					hib_volt}, wb_dat_i, wb_sel_i));
				`GPMC_ADR_FLASH_VOLT: flash_volt <= 16'(merge({16'h0000,
					flash_volt}, wb_dat_i, wb_sel_i));
				`GPMC_ADR_WAIT: wait_time <= 16'(merge({16'h0000,
					wait_time}, wb_dat_i, wb_sel_i));
				default: sleep_cur <= sleep_cur;
			endcase
		end
	end

	// Counters saturate so that a long run of resets cannot wrap to zero.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			cnt_full <= 8'h00;
			cnt_part <= 8'h00;
		end
		else if (wr_cmd && cmd == `GPMC_CMD_RESET_FULL && cnt_full != 8'hFF)
			cnt_full <= 8'(cnt_full + 8'h01);
		else if (wr_cmd && cmd == `GPMC_CMD_RESET_PART && cnt_part != 8'hFF)
			cnt_part <= 8'(cnt_part + 8'h01);
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			sync3 <= 1'b1;
			power_state <= gpmc_pkg::ST_NORMAL;
		end
		else
		begin
			sync1 <= comm_line_pin;
			sync2 <= sync1;
			sync3 <= sync2;
			power_state <= next_state;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			wait_cnt <= 16'h0000;
		else if (enter_sleep)
			wait_cnt <= wait_time;
		else if (power_state == gpmc_pkg::ST_SLEEP && meas_tick
			&& wait_cnt != 16'h0000)
			wait_cnt <= 16'(wait_cnt - 16'h0001);
	end

	// The stretch is bounded so the host never sees the line stuck.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			hold_cnt <= 32'h00000000;
		else if (low_power && comm_edge)
			hold_cnt <= STRETCH_CYCLES;
		else if (hold_cnt != 32'h00000000)
			hold_cnt <= 32'(hold_cnt - 32'h00000001);
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			freeze_cnt <= 32'h00000000;
		else if (hib_wake)
			freeze_cnt <= FREEZE_CYCLES;
		else if (freeze_cnt != 32'h00000000)
			freeze_cnt <= 32'(freeze_cnt - 32'h00000001);
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			temp_cnt <= 32'h00000000;
		else if (!temp_moved || cal_finish)
			temp_cnt <= 32'h00000000;
		else if (temp_cnt < TEMP_HOLD_CYCLES)
			temp_cnt <= 32'(temp_cnt + 32'h00000001);
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			cal_run <= 1'b0;
			cal_v_start <= 16'h0000;
			offset <= 16'h0000;
			v_ref <= 16'h0000;
			t_ref <= 8'h00;
		end
		else if (cal_start)
		begin
			cal_run <= 1'b1;
			cal_v_start <= volt;
		end
		else if (cal_abort)
			cal_run <= 1'b0;
		else if (cal_finish)
		begin
			cal_run <= 1'b0;
			offset <= offset_meas;
			v_ref <= volt;
			t_ref <= temp;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			current_corrected <= 16'h0000;
			wake_prev <= 1'b0;
			wake_irq <= 1'b0;
			hf_osc_enable <= 1'b1;
			line_hold_low <= 1'b0;
			shutdown_enable_pin <= 1'b0;
			report_frozen <= 1'b0;
			data_refresh <= 1'b0;
			flash_grant <= 1'b0;
			flash_refused <= 1'b0;
		end
		else
		begin
			if (!cal_run)
				current_corrected <= 16'(meas.sense_raw - offset);
			wake_prev <= wake_beyond;
			wake_irq <= wake_hit;
			hf_osc_enable <= next_state != gpmc_pkg::ST_DOZE;
			line_hold_low <= (low_power && comm_edge)
				|| hold_cnt > 32'h00000001;
			if (power_state == gpmc_pkg::ST_NORMAL && hib_go)
				shutdown_enable_pin <= low_cell;
			else if (hib_wake)
				shutdown_enable_pin <= 1'b0;
			report_frozen <= hib_wake || freeze_cnt > 32'h00000001;
			data_refresh <= meas_tick && power_state != gpmc_pkg::ST_HIBER
				&& !report_frozen;
			flash_grant <= flash_req && volt >= flash_volt;
			flash_refused <= flash_req && volt < flash_volt;
		end
	end
endmodule : gpmc_top

//--- verification/gpmc_props.sv
// Port checker of the power mode sequencer.
module gpmc_props #(
	parameter logic [31:0] STRETCH_CYCLES = 32'h00000014,
	parameter logic [31:0] FREEZE_CYCLES = 32'h00000032
)(
	input wire logic clk,
	input wire logic rstn,
	input wire gpmc_pkg::gpmc_meas_type meas,
	input wire logic meas_tick,
	input wire logic addressed_self,
	input wire logic flash_req,
	input wire logic comm_line_pin,
	input wire gpmc_pkg::gpmc_state_type power_state,
	input wire logic hf_osc_enable,
	input wire logic line_hold_low,
	input wire logic cal_run,
	input wire logic flash_grant,
	input wire logic flash_refused,
	input wire logic report_frozen,
	input wire logic data_refresh,
	input wire logic [15:0] current_corrected
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	logic [31:0] hold_cnt;
	logic [31:0] frz_cnt;
	logic out_rng;
	assign out_rng = $signed(meas.temperature) <= 8'sh05 ||
		$signed(meas.temperature) >= 8'sh2D;
	// Run lengths are counted here, far beyond what a repetition can unroll.
	always_ff @(posedge clk)
	begin
		hold_cnt <= line_hold_low ? hold_cnt + 32'h1 : 32'h0;
		frz_cnt <= report_frozen ? frz_cnt + 32'h1 : 32'h0;
	end
	a_flash_answer: assert property (flash_req |-> ##[1:2]
		(flash_grant ^ flash_refused)) else $error("flash unanswered");
	a_doze_osc: assert property (power_state == gpmc_pkg::ST_DOZE
		|-> !hf_osc_enable) else $error("oscillator runs in doze");
	a_hib_hold: assert property (power_state == gpmc_pkg::ST_HIBER &&
		!addressed_self |=> power_state == gpmc_pkg::ST_HIBER)
		else $error("hibernate left without traffic");
	a_hib_wake: assert property (power_state == gpmc_pkg::ST_HIBER &&
		addressed_self |=> power_state == gpmc_pkg::ST_NORMAL &&
		report_frozen) else $error("hibernate wake wrong");
	a_freeze_len: assert property ($fell(report_frozen) |->
		frz_cnt == FREEZE_CYCLES) else $error("freeze length wrong");
	a_stretch_len: assert property ($fell(line_hold_low) |->
		hold_cnt == STRETCH_CYCLES) else $error("stretch length wrong");
	a_doze_exit: assert property (power_state == gpmc_pkg::ST_DOZE &&
		$fell(comm_line_pin) |-> ##[1:6] power_state != gpmc_pkg::ST_DOZE)
		else $error("doze kept after traffic");
	a_cal_skip: assert property ($past(power_state) ==
		gpmc_pkg::ST_NORMAL && power_state inside {gpmc_pkg::ST_CAL_PRE,
		gpmc_pkg::ST_SLEEP} |-> (power_state == gpmc_pkg::ST_SLEEP) ==
		$past(out_rng)) else $error("sleep entry calibration wrong");
	a_cal_state: assert property (power_state == gpmc_pkg::ST_CAL_PRE
		|-> cal_run) else $error("no calibration before sleep");
	a_cal_hold: assert property (cal_run && $past(cal_run) |->
		$stable(current_corrected)) else $error("current moved in cal");
	a_refresh_src: assert property (data_refresh |-> $past(meas_tick) &&
		$past(power_state) != gpmc_pkg::ST_HIBER && !$past(report_frozen))
		else $error("refresh without tick");
	c_doze: cover property (power_state == gpmc_pkg::ST_DOZE);
	c_wake: cover property (power_state == gpmc_pkg::ST_HIBER && addressed_self);
	c_hold: cover property ($rose(line_hold_low));
endmodule : gpmc_props

//--- verification/gpmc_host_model.sv
// Host side of the comm line: frames of line activity and address match.
module gpmc_host_model (
	input wire logic clk,
	input wire logic kick,
	input wire logic to_me,
	input wire logic line_hold_low,
	output logic comm_line_pin,
	output logic addressed_self
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] low_cnt = 3'h0;
	logic me = 1'h0;
	initial
	begin
		comm_line_pin = 1'h1;
		addressed_self = 1'h0;
	end
	always @(posedge clk)
	begin
		addressed_self <= 1'h0;
		if (low_cnt != 3'h0)
		begin
			low_cnt <= low_cnt - 3'h1;
			comm_line_pin <= (low_cnt == 3'h1);
			addressed_self <= me && (low_cnt == 3'h1);
		end
		// A new frame waits while the device stretches the line.
		else if (kick && !line_hold_low)
		begin
			low_cnt <= 3'h4;
			me <= to_me;
			comm_line_pin <= 1'h0;
		end
	end
endmodule : gpmc_host_model

//--- verification/tb.sv
// Self-checking bench of the power mode sequencer.
`include "gpmc_defs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} gpmc_row_type;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic cyc = 1'h0;
	logic stb = 1'h0;
	logic we = 1'h0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	gpmc_pkg::gpmc_meas_type meas = '0;
	logic meas_tick = 1'h0;
	logic ocv_valid = 1'h0;
	logic cal_done = 1'h0;
	logic [15:0] offset_meas = 16'h0;
	logic flash_req = 1'h0;
	logic kick = 1'h0;
	logic to_me = 1'h0;
	logic comm_line_pin;
	logic addressed_self;
	gpmc_pkg::gpmc_state_type power_state;
	logic hf_osc_enable;
	logic line_hold_low;
	logic cal_run;
	logic flash_grant;
	logic flash_refused;
	logic shutdown_enable_pin;
	logic report_frozen;
	logic data_refresh;
	logic [15:0] current_corrected;
	logic wake_irq;
	logic [3:0] tk = 4'h0;
	logic [31:0] q;
	int error_cnt = 0;
	int compares = 0;
	int n;
	gpmc_row_type rows [11] = '{
		'{`GPMC_ADR_CFG, 32'hFFFFFFFF, 32'h0000007F},
		'{`GPMC_ADR_CFG, 32'h0, 32'h0},
		'{`GPMC_ADR_SLEEP_CUR, 32'hFFFF0032, 32'h00000032},
		'{`GPMC_ADR_HIB_CUR, 32'h00000014, 32'h00000014},
		'{`GPMC_ADR_HIB_VOLT, 32'h00000DAC, 32'h00000DAC},
		'{`GPMC_ADR_FLASH_VOLT, 32'h00000E42, 32'h00000E42},
		'{`GPMC_ADR_WAIT, 32'hFFFF0000, 32'h0},
		'{`GPMC_ADR_CMD, 32'h0, 32'h0},
		'{`GPMC_ADR_STATUS, 32'hFFFFFFFF, 32'h0},
		'{`GPMC_ADR_RST_CNT, 32'hFFFFFFFF, 32'h0},
		'{8'h40, 32'h12345678, 32'h0}};
	logic [15:0] wk [2] = '{16'hFFFA, 16'h0010};
	gpmc_top #(.STRETCH_CYCLES(32'h14), .FREEZE_CYCLES(32'h32),
		.TEMP_HOLD_CYCLES(32'h1E)) dut_u (.clk(clk), .rstn(rstn),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.meas(meas), .meas_tick(meas_tick), .ocv_valid(ocv_valid),
		.cal_done(cal_done), .offset_meas(offset_meas),
		.addressed_self(addressed_self), .flash_req(flash_req),
		.comm_line_pin(comm_line_pin), .power_state(power_state),
		.hf_osc_enable(hf_osc_enable), .line_hold_low(line_hold_low),
		.cal_run(cal_run), .flash_grant(flash_grant),
		.flash_refused(flash_refused),
		.shutdown_enable_pin(shutdown_enable_pin),
		.report_frozen(report_frozen), .data_refresh(data_refresh),
		.current_corrected(current_corrected), .wake_irq(wake_irq));
	gpmc_host_model host_u (.clk(clk), .kick(kick), .to_me(to_me),
		.line_hold_low(line_hold_low), .comm_line_pin(comm_line_pin),
		.addressed_self(addressed_self));
	always #50 clk = ~clk;
	always @(posedge clk)
	begin
		tk <= tk + 4'h1;
		meas_tick <= (tk == 4'hF);
	end
	task report_and_stop;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// The request stays up until ack is sampled, for at most 20 cycles; then the bench stops.
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (ack === 1'h1)
				break;
		end
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
		if (i == 20)
		begin
			error_cnt++;
			report_and_stop();
		end
	endtask : wb
	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'h0, a, 32'h0);
		chk(nm, q, e);
	endtask : rd
	task wait_st(input gpmc_pkg::gpmc_state_type s);
		int i;
		for (i = 0; i < 300 && power_state !== s; i++)
			@(posedge clk);
		chk("state", 32'(power_state), 32'(s));
		if (power_state !== s)
			report_and_stop();
	endtask : wait_st
	task wait_cal(input logic v);
		int i;
		for (i = 0; i < 20 && cal_run !== v; i++)
			@(posedge clk);
		chk("cal_run", 32'(cal_run), 32'(v));
	endtask : wait_cal
	task pulse_done;
		@(posedge clk);
		cal_done <= 1'h1;
		@(posedge clk);
		cal_done <= 1'h0;
	endtask : pulse_done
	task hold_len(input logic f, input logic [31:0] e);
		int i;
		int c;
		c = 0;
		for (i = 0; i < 300 && (f ? report_frozen : line_hold_low) !== 1'h1; i++)
			@(posedge clk);
		while ((f ? report_frozen : line_hold_low) === 1'h1 && c < 300)
		begin
			@(posedge clk);
			c++;
		end
		chk("run length", 32'(c), e);
	endtask : hold_len
	task traffic(input logic m);
		int i;
		@(posedge clk);
		kick <= 1'h1;
		to_me <= m;
		for (i = 0; i < 300 && comm_line_pin !== 1'h0; i++)
			@(posedge clk);
		kick <= 1'h0;
	endtask : traffic
	task flash(input logic [15:0] v, input logic [1:0] e);
		logic [1:0] s;
		@(posedge clk);
		meas.voltage <= v;
		@(posedge clk);
		flash_req <= 1'h1;
		@(posedge clk);
		flash_req <= 1'h0;
		s = 2'h0;
		repeat (3)
		begin
			@(posedge clk);
			s = s | {flash_grant, flash_refused};
		end
		chk("flash", 32'(s), 32'(e));
	endtask : flash
	initial
	begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rstn <= 1'h1;
		@(posedge clk);
		chk("osc", 32'(hf_osc_enable), 32'h1);
		chk("state", 32'(power_state), 32'(gpmc_pkg::ST_NORMAL));
		foreach (rows[k])
		begin
			wb(1'h1, rows[k].a, rows[k].d);
			rd(rows[k].a, rows[k].e, "register");
		end
		$display("registers done");
		wb(1'h1, `GPMC_ADR_CMD, 32'h2);
		wb(1'h1, `GPMC_ADR_CMD, 32'h2);
		wb(1'h1, `GPMC_ADR_CMD, 32'h3);
		rd(`GPMC_ADR_RST_CNT, 32'h0102, "reset count");
		$display("reset counts done");
		meas <= '{16'h000A, 16'h0E74, 8'h19, 16'h0064};
		offset_meas <= 16'h0005;
		wait_cal(1'h1);
		meas.voltage <= 16'h0E53;
		meas.avg_current <= 16'h00C8;
		wait_cal(1'h0);
		meas.avg_current <= 16'h000A;
		wait_cal(1'h1);
		pulse_done();
		repeat (3) @(posedge clk);
		chk("current", 32'(current_corrected), 32'h005F);
		flash(16'h0E41, 2'h1);
		flash(16'h0E42, 2'h2);
		$display("calibration and flash done");
		wb(1'h1, `GPMC_ADR_CFG, 32'h1);
		wait_st(gpmc_pkg::ST_CAL_PRE);
		pulse_done();
		wait_st(gpmc_pkg::ST_SLEEP);
		traffic(1'h0);
		hold_len(1'h0, 32'h14);
		wb(1'h1, `GPMC_ADR_CFG, 32'h3);
		wait_st(gpmc_pkg::ST_DOZE);
		chk("osc", 32'(hf_osc_enable), 32'h0);
		traffic(1'h0);
		wait_st(gpmc_pkg::ST_SLEEP);
		rd(`GPMC_ADR_CFG, 32'h1, "config");
		$display("sleep and doze done");
		meas.sense_raw <= 16'h0005;
		wb(1'h1, `GPMC_ADR_CFG, 32'h21);
		foreach (wk[k])
		begin
			meas.sense_raw <= wk[k];
			for (n = 0; n < 20 && wake_irq !== 1'h1; n++) @(posedge clk);
			chk("wake", 32'(wake_irq), 32'h1);
			wait_st(gpmc_pkg::ST_NORMAL);
			meas.sense_raw <= 16'h0005;
			wait_st(gpmc_pkg::ST_CAL_PRE);
			pulse_done();
			wait_st(gpmc_pkg::ST_SLEEP);
		end
		meas.avg_current <= 16'h003C;
		wait_st(gpmc_pkg::ST_NORMAL);
		meas.temperature <= 8'h32;
		meas.avg_current <= 16'h000A;
		wait_st(gpmc_pkg::ST_SLEEP);
		meas.temperature <= 8'h19;
		meas.avg_current <= 16'h003C;
		wait_st(gpmc_pkg::ST_NORMAL);
		wb(1'h1, `GPMC_ADR_CFG, 32'h0);
		meas.avg_current <= 16'h000A;
		$display("wake and skip done");
		meas.voltage <= 16'h0D7A;
		ocv_valid <= 1'h1;
		wait_st(gpmc_pkg::ST_HIBER);
		chk("shutdown", 32'(shutdown_enable_pin), 32'h1);
		ocv_valid <= 1'h0;
		traffic(1'h0);
		repeat (8) @(posedge clk);
		chk("state", 32'(power_state), 32'(gpmc_pkg::ST_HIBER));
		traffic(1'h1);
		wait_st(gpmc_pkg::ST_NORMAL);
		hold_len(1'h1, 32'h32);
		meas.voltage <= 16'h0E42;
		ocv_valid <= 1'h1;
		wb(1'h1, `GPMC_ADR_CFG, 32'hC);
		repeat (8) @(posedge clk);
		chk("state", 32'(power_state), 32'(gpmc_pkg::ST_NORMAL));
		wb(1'h1, `GPMC_ADR_CFG, 32'h4);
		wait_st(gpmc_pkg::ST_HIBER);
		chk("shutdown", 32'(shutdown_enable_pin), 32'h0);
		ocv_valid <= 1'h0;
		traffic(1'h1);
		wait_st(gpmc_pkg::ST_NORMAL);
		rd(`GPMC_ADR_CFG, 32'h0, "config");
		$display("hibernate done");
		report_and_stop();
	end
endmodule : tb
bind gpmc_top gpmc_props #(.STRETCH_CYCLES(STRETCH_CYCLES),
	.FREEZE_CYCLES(FREEZE_CYCLES)) props_u (.clk(clk), .rstn(rstn),
	.meas(meas), .meas_tick(meas_tick), .addressed_self(addressed_self),
	.flash_req(flash_req), .comm_line_pin(comm_line_pin),
	.power_state(power_state), .hf_osc_enable(hf_osc_enable),
	.line_hold_low(line_hold_low), .cal_run(cal_run),
	.flash_grant(flash_grant), .flash_refused(flash_refused),
	.report_frozen(report_frozen), .data_refresh(data_refresh),
	.current_corrected(current_corrected));
